// file: bench/gdr_host.sv
// host bus master model: axi4-lite single write and single read tasks
// assumes the bench calls one task at a time on clock
`timescale 1ns/1ps
module gdr_host (
  input wire logic clock, // bus clock
  output logic [7:0] awaddr, // write address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // byte strobes
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [7:0] araddr, // read address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready // read data ready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one write; released payload is inverted so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    repeat ($urandom_range(0, 2)) @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clock);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!dd && wready === 1'b1) begin
        dd = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    repeat ($urandom_range(0, 2)) @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : gdr_host

// file: bench/gdr_regs_asserts.sv
// checker for the gate driver control bank, bound to gdr_regs
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module gdr_regs_asserts
  import gdr_pkg::*;
(
  input wire logic clock, // bank clock
  input wire logic rst_b, // reset, active low
  input wire logic s_axi_bvalid, // write response valid
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic gate_output_enable, // driver enabled
  input wire logic spread_spectrum_off, // spread spectrum off
  input wire logic gate_handshake_off, // handshake off
  input wire logic [1:0] bridge_control_mode, // control scheme
  input wire logic freewheel_side_select, // freewheel side
  input wire logic input1_signal, // selected input one
  input wire logic input2_signal, // selected input two
  input wire logic half1_pulldown, // half 1 pulldowns
  input wire logic half2_pulldown, // half 2 pulldowns
  input wire logic [3:0] high_side_source_current, // hs source
  input wire logic [3:0] high_side_sink_current, // hs sink
  input wire logic [3:0] low_side_source_current, // ls source
  input wire logic [3:0] low_side_sink_current, // ls sink
  input wire logic clear_latched_faults, // clear pulse
  input wire logic regs_locked // bank locked
);
  // ----------------------------------------
  // helper and defaults
  // ----------------------------------------
  logic [21:0] ctl; // control outputs taken straight from register fields, clear pulse and lock flag excluded
  assign ctl = {gate_output_enable, spread_spectrum_off, gate_handshake_off,
    bridge_control_mode, freewheel_side_select, high_side_source_current,
    high_side_sink_current, low_side_source_current, low_side_sink_current};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_clear_single: assert property (
    clear_latched_faults |=> !clear_latched_faults)
    else $error("clear pulse longer than one cycle");
  a_clear_cause: assert property (
    $rose(clear_latched_faults) |-> $rose(s_axi_bvalid))
    else $error("clear pulse without a write");
  a_off_pulls: assert property (
    !gate_output_enable && !$past(gate_output_enable)
    |-> half1_pulldown && half2_pulldown)
    else $error("pulldowns off while driver disabled");
  a_off_inputs: assert property (
    !gate_output_enable |-> !input1_signal && !input2_signal)
    else $error("inputs pass while driver disabled");
  a_float_halfonly: assert property (
    gate_output_enable && $past(gate_output_enable)
    && bridge_control_mode != MODE_HALF
    && $past(bridge_control_mode) != MODE_HALF
    |-> !half1_pulldown && !half2_pulldown)
    else $error("float outside half-bridge mode");
  a_locked_hold: assert property (
    $past(regs_locked) |-> $stable(ctl))
    else $error("control changed while locked");
  a_lock_edge: assert property (
    $changed(regs_locked) |-> $rose(s_axi_bvalid))
    else $error("lock state changed without a write");
  a_ctl_edge: assert property (
    $changed(ctl) |-> $rose(s_axi_bvalid))
    else $error("control changed without a write");
  c_clear: cover property (clear_latched_faults);
  c_locked: cover property ($rose(regs_locked));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : gdr_regs_asserts

bind gdr_regs gdr_regs_asserts u_chk (.*);

// file: bench/gdr_regs_bench.sv
// self-checking bench of the gate driver control bank
// assumes gdr_host as bus master and a behavioural register model
`timescale 1ns/1ps
module gdr_regs_bench;
  import gdr_pkg::*;
  logic clock = 0;
  logic rst_b = 0;
  logic in1 = 0, in2 = 0, f1b = 1, f2b = 1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bmode;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic en, ssc, hso, fw, i1, i2, p1, p2, clr, lkd;
  logic [3:0] hsp, hsn, lsp, lsn;
  logic [7:0] m [4];
  bit lk;
  int error_cnt = 0, checks = 0, cyc = 0, pulses = 0, npulse = 0;
  // ----------------------------------------
  // clock, watchdog, instances
  // ----------------------------------------
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    pulses <= pulses + (clr === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  gdr_host u_host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  gdr_regs u_dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .input1_pin(in1),
    .input2_pin(in2), .float_pin_half1_b(f1b), .float_pin_half2_b(f2b),
    .gate_output_enable(en), .spread_spectrum_off(ssc),
    .gate_handshake_off(hso), .bridge_control_mode(bmode),
    .freewheel_side_select(fw), .input1_signal(i1), .input2_signal(i2),
    .half1_pulldown(p1), .half2_pulldown(p2),
    .high_side_source_current(hsp), .high_side_sink_current(hsn),
    .low_side_source_current(lsp), .low_side_sink_current(lsn),
    .clear_latched_faults(clr), .regs_locked(lkd));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic cmp(input string s, input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask : cmp
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    m = '{RST_DEV_CFG, RST_BRG_CFG, RST_HS_CUR, RST_LS_CUR};
    lk = 0;
  endtask : do_reset
  // read back one place and compare every output except the clear pulse with the model
  task automatic rdchk(input int i);
    logic [31:0] q;
    logic [1:0] r;
    logic e1, e2, x1, x2;
    u_host.rd(ADDR_DEV_CFG + 8'(4 * i), q, r);
    cmp("rdata", q, i > 3 ? 32'h0 : {24'h0, m[i]});
    cmp("rresp", r, i > 3 ? RESP_SLVERR : RESP_OKAY);
    repeat (4) @(posedge clock);
    e1 = m[0][7] & (m[0][5] ? m[1][3] : in1);
    e2 = m[0][7] & (m[0][4] ? m[1][2] : in2);
    x1 = !m[0][7] | (m[1][6:5] == MODE_HALF & (m[1][1] | !f1b));
    x2 = !m[0][7] | (m[1][6:5] == MODE_HALF & (m[1][0] | !f2b));
    cmp("outputs", {en, ssc, hso, bmode, fw, hsp, hsn, lsp, lsn, lkd},
      {m[0][7:6], m[1][7:4], m[2], m[3], lk});
    cmp("pins", {i1, i2, p1, p2}, {e1, e2, x1, x2});
  endtask : rdchk
  // one write through the model, then a read back of the same place
  task automatic op(input int i, input logic [7:0] d, input logic [3:0] s);
    logic [1:0] r;
    @(posedge clock);
    {in1, in2, f1b, f2b} <= 4'($urandom);
    u_host.wr(ADDR_DEV_CFG + 8'(4 * i), {24'($urandom), d}, s, r);
    cmp("bresp", r, i > 3 ? RESP_SLVERR : RESP_OKAY);
    if (i < 4 && s[0]) begin
      if (!lk) m[i] = i == 0 ? {d[7:1], 1'b0} : d;
      else if (i == 0) m[0][3:1] = d[3:1];
      if (i == 0 && !lk && d[0]) npulse++;
      if (i == 0 && d[3:1] == KEY_LOCK) lk = 1;
      else if (i == 0 && d[3:1] == KEY_UNLOCK) lk = 0;
    end
    rdchk(i);
  endtask : op
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(4886));
    do_reset();
    for (int i = 0; i < 5; i++) rdchk(i);
    op(0, 8'hb6, 4'hf);
    for (int k = 0; k < 4; k++) op(1, {1'($urandom), 2'(k), 5'($urandom)},
      4'hf);
    op(0, 8'hc6, 4'hf);
    op(0, 8'hcc, 4'hf);
    op(2, 8'h12, 4'hf);
    op(0, 8'hca, 4'hf);
    op(0, 8'h07, 4'hf);
    op(0, 8'h87, 4'hf);
    op(2, 8'h00, 4'hf);
    op(3, 8'h0f, 4'he);
    op(4, 8'h55, 4'hf);
    for (int n = 0; n < 60; n++)
      op($urandom_range(0, 4), 8'($urandom),
        $urandom_range(0, 7) == 0 ? 4'he : 4'hf);
    repeat (2) @(posedge clock);
    cmp("pulses", pulses, npulse);
    do_reset();
    for (int i = 0; i < 4; i++) rdchk(i);
    final_report();
  end
endmodule : gdr_regs_bench

// file: rtl/gdr_pkg.sv
// register map and field layout of the gate driver control bank
// assumes a 32-bit axi4-lite bus, one aligned word per register
package gdr_pkg;
  // register indices and byte addresses (index times four)
  localparam logic [3:0] IDX_DEV_CFG = 4'h4;
  localparam logic [3:0] IDX_BRG_CFG = 4'h5;
  localparam logic [3:0] IDX_HS_CUR = 4'h6;
  localparam logic [3:0] IDX_LS_CUR = 4'h7;
  localparam logic [7:0] ADDR_DEV_CFG = {2'h0, IDX_DEV_CFG, 2'h0};
  localparam logic [7:0] ADDR_BRG_CFG = {2'h0, IDX_BRG_CFG, 2'h0};
  localparam logic [7:0] ADDR_HS_CUR = {2'h0, IDX_HS_CUR, 2'h0};
  localparam logic [7:0] ADDR_LS_CUR = {2'h0, IDX_LS_CUR, 2'h0};
  // reset values
  localparam logic [7:0] RST_DEV_CFG = 8'h06;
  localparam logic [7:0] RST_BRG_CFG = 8'h00;
  localparam logic [7:0] RST_HS_CUR = 8'hff;
  localparam logic [7:0] RST_LS_CUR = 8'hff;
  // device_config fields
  localparam int DC_ENABLE = 7;
  localparam int DC_SSC_OFF = 6;
  localparam int DC_IN1_SEL = 5;
  localparam int DC_IN2_SEL = 4;
  localparam int DC_KEY_HI = 3;
  localparam int DC_KEY_LO = 1;
  localparam int DC_CLEAR = 0;
  // bridge_config fields
  localparam int BC_HS_OFF = 7;
  localparam int BC_MODE_HI = 6;
  localparam int BC_MODE_LO = 5;
  localparam int BC_FW = 4;
  localparam int BC_SOFT_IN1 = 3;
  localparam int BC_SOFT_IN2 = 2;
  localparam int BC_FLOAT1 = 1;
  localparam int BC_FLOAT2 = 0;
  // lock key codes
  localparam logic [2:0] KEY_UNLOCK = 3'h3;
  localparam logic [2:0] KEY_LOCK = 3'h6;
  // bridge modes
  localparam logic [1:0] MODE_HALF = 2'h0;
  localparam logic [1:0] MODE_PH_EN = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // states, one-hot
  typedef enum logic [1:0] {LK_OPEN = 2'b01, LK_SHUT = 2'b10} gdr_lock_t;
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} gdr_wr_t;
endpackage : gdr_pkg

// file: rtl/gdr_regs.sv
// control register bank of an h-bridge gate driver
// assumes an axi4-lite master on clock; pins arrive asynchronously
//
// Notes on behaviour
// R1: enable low forces pulldowns, ignores inputs; high lets inputs drive.
// R2: configuration bit 6 set turns spread spectrum clocking off.
// R3: configuration bit 5 picks pin or soft bit for input one.
// R4: configuration bit 4 picks pin or soft bit for input two.
// R5: key 011 unlocks, key 110 locks; locked bank takes only key writes.
// R6: any other key value leaves the lock state unchanged.
// R7: writing one to clear bit clears latched faults, bit returns to zero.
// R8: bridge bit 7 set disables the gate monitor dead-time handshake.
// R9: bridge bits 6-5 choose half, phase/enable, pwm or split control.
// R10: bridge bit 4 picks low-side or high-side freewheeling.
// R11: bridge bit 3 drives input one only when soft source selected.
// R12: bridge bit 2 drives input two only when soft source selected.
// R13: in half mode, bit 1 ORed with pin request floats half one.
// R14: in half mode, bit 0 ORed with pin request floats half two.
// R15: high-side source code 0..15 maps 0.5 mA up to 62 mA.
// R16: high-side sink code uses the same sixteen-step mapping.
// R17: low-side register holds source and sink codes, both reset 1111.
// R18: clear write gives one pulse, stored bit drops next cycle.
// R19: while locked, non-key bits of every register stay unchanged.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module gdr_regs
  import gdr_pkg::*;
(
  input wire logic clock, // 200 mhz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic input1_pin, // input/enable pin
  input wire logic input2_pin, // input/phase pin
  input wire logic float_pin_half1_b, // half 1 float request, low
  input wire logic float_pin_half2_b, // half 2 float request, low
  output logic gate_output_enable, // driver enabled
  output logic spread_spectrum_off, // spread spectrum disabled
  output logic gate_handshake_off, // dead-time handshake disabled
  output logic [1:0] bridge_control_mode, // input control scheme
  output logic freewheel_side_select, // 1 = high-side freewheel
  output logic input1_signal, // selected input one
  output logic input2_signal, // selected input two
  output logic half1_pulldown, // half 1 gate pulldowns on
  output logic half2_pulldown, // half 2 gate pulldowns on
  output logic [3:0] high_side_source_current, // hs source code
  output logic [3:0] high_side_sink_current, // hs sink code
  output logic [3:0] low_side_source_current, // ls source code
  output logic [3:0] low_side_sink_current, // ls sink code
  output logic clear_latched_faults, // one-cycle fault clear pulse
  output logic regs_locked // bank is write-locked
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------

  // map a byte address to {hit, register slot}
  function automatic logic [2:0] map_index(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      ADDR_DEV_CFG: r = 3'h4;
      ADDR_BRG_CFG: r = 3'h5;
      ADDR_HS_CUR: r = 3'h6;
      ADDR_LS_CUR: r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : map_index

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------

  logic [7:0] dev_cfg_reg;
  logic [7:0] brg_cfg_reg;
  logic [7:0] hs_cur_reg;
  logic [7:0] ls_cur_reg;
  gdr_lock_t lock_reg;
  gdr_wr_t wr_state_reg;
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic w_held_reg;
  logic [1:0] bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rvalid_reg;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] flt_meta_reg;
  logic [1:0] flt_sync_reg;
  logic [1:0] in_sel_reg;
  logic [1:0] pulldown_reg;
  logic [2:0] wr_map;
  logic wr_fire;
  logic wr_dev;
  logic wr_brg;
  logic wr_hs;
  logic wr_ls;
  logic open_now;
  logic [2:0] key_in;

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------

  assign s_axi_awready = !aw_held_reg && (wr_state_reg == WR_IDLE);
  assign s_axi_wready = !w_held_reg && (wr_state_reg == WR_IDLE);
  assign s_axi_bvalid = (wr_state_reg == WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // hold address and data until both have arrived
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      wlane_reg <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_reg <= 1'b0;
    end
  end

  // write happens once, in the cycle both halves are held
  assign wr_fire = aw_held_reg && w_held_reg && (wr_state_reg == WR_IDLE);
  assign wr_map = map_index(awaddr_reg);
  assign wr_dev = wr_fire && wlane_reg && (wr_map == 3'h4);
  assign wr_brg = wr_fire && wlane_reg && (wr_map == 3'h5);
  assign wr_hs = wr_fire && wlane_reg && (wr_map == 3'h6);
  assign wr_ls = wr_fire && wlane_reg && (wr_map == 3'h7);
  assign key_in = wdata_reg[DC_KEY_HI:DC_KEY_LO];
  assign open_now = (lock_reg == LK_OPEN);

  // response sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_state_reg <= WR_IDLE;
      bresp_reg <= RESP_OKAY;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= WR_RESP;
            bresp_reg <= wr_map[2] ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= WR_IDLE;
          end
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // lock state
  // ------------------------------------------------------------

  // R5 key codes open or shut
  // R6 other keys hold state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lock_reg <= LK_OPEN;
    end else if (wr_dev) begin
      case (key_in)
        KEY_UNLOCK: lock_reg <= LK_OPEN;
        KEY_LOCK: lock_reg <= LK_SHUT;
        default: lock_reg <= lock_reg;
      endcase
    end
  end

  assign regs_locked = (lock_reg == LK_SHUT);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  // device_config; key field always writable
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dev_cfg_reg <= RST_DEV_CFG;
    end else if (wr_dev) begin
      dev_cfg_reg[DC_KEY_HI:DC_KEY_LO] <= key_in;
      // R19 locked keeps other bits
      if (open_now) begin
        dev_cfg_reg[7:4] <= wdata_reg[7:4];
        dev_cfg_reg[DC_CLEAR] <= wdata_reg[DC_CLEAR];
      end else begin
        dev_cfg_reg[DC_CLEAR] <= 1'b0;
      end
    end else begin
      // R18 clear bit drops next cycle
      dev_cfg_reg[DC_CLEAR] <= 1'b0;
    end
  end

  // R7 one-cycle fault clear
  assign clear_latched_faults = dev_cfg_reg[DC_CLEAR];

  // bridge_config
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      brg_cfg_reg <= RST_BRG_CFG;
    end else if (wr_brg && open_now) begin
      brg_cfg_reg <= wdata_reg;
    end
  end

  // R15 high-side source and sink codes
  // R16 same mapping for sink
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hs_cur_reg <= RST_HS_CUR;
    end else if (wr_hs && open_now) begin
      hs_cur_reg <= wdata_reg;
    end
  end

  // R17 low-side codes, reset 1111
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ls_cur_reg <= RST_LS_CUR;
    end else if (wr_ls && open_now) begin
      ls_cur_reg <= wdata_reg;
    end
  end

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // one read in flight, answered the cycle after the address
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      case (map_index(s_axi_araddr))
        3'h4: rdata_reg <= {24'h000000, dev_cfg_reg};
        3'h5: rdata_reg <= {24'h000000, brg_cfg_reg};
        3'h6: rdata_reg <= {24'h000000, hs_cur_reg};
        3'h7: rdata_reg <= {24'h000000, ls_cur_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------

  // two flops per pin, index 0 = half one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      flt_meta_reg <= 2'h3;
      flt_sync_reg <= 2'h3;
    end else begin
      pin_meta_reg <= {input2_pin, input1_pin};
      pin_sync_reg <= pin_meta_reg;
      flt_meta_reg <= {float_pin_half2_b, float_pin_half1_b};
      flt_sync_reg <= flt_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // per half-bridge output control
  // ------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_half
      logic src_soft;
      logic soft_val;
      logic soft_float;
      logic float_req;
      logic sel_bit_reg;
      logic pull_bit_reg;
      // R3 R4 source select bits
      assign src_soft = (gi == 0) ? dev_cfg_reg[DC_IN1_SEL] :
                                    dev_cfg_reg[DC_IN2_SEL];
      // R11 R12 soft input bits
      assign soft_val = (gi == 0) ? brg_cfg_reg[BC_SOFT_IN1] :
                                    brg_cfg_reg[BC_SOFT_IN2];
      assign soft_float = (gi == 0) ? brg_cfg_reg[BC_FLOAT1] :
                                      brg_cfg_reg[BC_FLOAT2];
      // R13 R14 float request, half mode only
      assign float_req = (brg_cfg_reg[BC_MODE_HI:BC_MODE_LO] == MODE_HALF)
                         && (soft_float || !flt_sync_reg[gi]);

      // selected input, registered
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          sel_bit_reg <= 1'b0;
        end else begin
          sel_bit_reg <= src_soft ? soft_val : pin_sync_reg[gi];
        end
      end
      assign in_sel_reg[gi] = sel_bit_reg;

      // R1 disabled driver pulls both gates down
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          pull_bit_reg <= 1'b1;
        end else begin
          pull_bit_reg <= !dev_cfg_reg[DC_ENABLE] || float_req;
        end
      end
      assign pulldown_reg[gi] = pull_bit_reg;
    end
  endgenerate

  // R1 inputs ignored while disabled
  assign input1_signal = in_sel_reg[0] && dev_cfg_reg[DC_ENABLE];
  assign input2_signal = in_sel_reg[1] && dev_cfg_reg[DC_ENABLE];
  assign half1_pulldown = pulldown_reg[0];
  assign half2_pulldown = pulldown_reg[1];

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------

  assign gate_output_enable = dev_cfg_reg[DC_ENABLE];
  // R2 spread spectrum off
  assign spread_spectrum_off = dev_cfg_reg[DC_SSC_OFF];
  // R8 handshake off
  assign gate_handshake_off = brg_cfg_reg[BC_HS_OFF];
  // R9 bridge control mode
  assign bridge_control_mode = brg_cfg_reg[BC_MODE_HI:BC_MODE_LO];
  // R10 freewheel side
  assign freewheel_side_select = brg_cfg_reg[BC_FW];
  assign high_side_source_current = hs_cur_reg[7:4];
  assign high_side_sink_current = hs_cur_reg[3:0];
  assign low_side_source_current = ls_cur_reg[7:4];
  assign low_side_sink_current = ls_cur_reg[3:0];

endmodule : gdr_regs
